// >>> ardg_defs.svh
`ifndef ARDG_DEFS_SVH
`define ARDG_DEFS_SVH

// Register byte addresses on the Avalon-MM slave.
`define ARDG_OFFSET_ADR      32'h4000_D008
`define ARDG_GAIN_ADR        32'h4000_D00C
`define ARDG_CFG_ADR         32'h4000_D010
`define ARDG_STAT_ADR        32'h4000_D014
`define ARDG_BEG_ADR         32'h4000_D018
`define ARDG_SIZE_ADR        32'h4000_D01C
`define ARDG_CUR_ADR         32'h4000_D020
`define ARDG_EVT_ADR         32'h4000_D028

// Reset values.
`define ARDG_GAIN_RST        16'h8000
`define ARDG_OFFSET_RST      16'h0000
`define ARDG_SIZE_RST        13'h0000
`define ARDG_RAM_BASE        32'h2000_0000

// Field widths and positions.
`define ARDG_PTR_W           14
`define ARDG_SIZE_W          13
`define ARDG_CFG_LOAD        0
`define ARDG_CFG_WRAP        1
`define ARDG_CFG_RST         4
`define ARDG_STAT_ACT        0
`define ARDG_STAT_OVF        1
`define ARDG_EVT_HALF        1
`define ARDG_EVT_FULL        2
`define ARDG_EVT_SAT         3
`define ARDG_EVT_OVF         4

// Gain scaling: the binary point sits between bits 15 and 14.
`define ARDG_GAIN_FRAC       15

`endif

// >>> ardg_pkg.sv
package ardg_pkg;

  // DMA states, Gray-coded along idle -> run -> write -> run; write -> idle changes both bits.
  typedef enum logic [1:0] {
    ARDG_IDLE  = 2'h0,
    ARDG_RUN   = 2'h1,
    ARDG_WRITE = 2'h3
  } ardg_state_type;

  typedef logic [15:0] ardg_sample_type;

endpackage

// >>> ardg_gain.sv
`include "ardg_defs.svh"

module ardg_gain (
  input  wire logic                  clk_i,
  input  wire logic                  rst_b_i,
  input  wire logic                  valid_i,
  input  wire ardg_pkg::ardg_sample_type data_i,
  input  wire logic [15:0]           offset_i,
  input  wire logic [15:0]           gain_i,
  output logic                       valid_o,
  output ardg_pkg::ardg_sample_type  result_o,
  output logic                       sat_o
);

  logic        [16:0] sum_wide;
  logic               sum_ovf;
  logic signed [15:0] sum_sat;
  logic signed [32:0] product;
  logic               prod_ovf;
  logic        [15:0] prod_sat;
  logic               valid_q;
  logic        [15:0] result_q;
  logic               sat_q;

  // The offset sum is clamped too, so a large offset cannot wrap the sign.
  assign sum_wide = {data_i[15], data_i} + {offset_i[15], offset_i};
  assign sum_ovf  = sum_wide[16] ^ sum_wide[15];
  assign sum_sat  = sum_ovf ? (sum_wide[16] ? 16'sh8000 : 16'sh7FFF) : $signed(sum_wide[15:0]);

  // Gain is unsigned Q1.15, so it is zero-extended before the signed multiply.
  assign product  = sum_sat * $signed({1'b0, gain_i});
  assign prod_ovf = ~((product[32:30] == 3'h0) | (product[32:30] == 3'h7));
  assign prod_sat = prod_ovf ? (product[32] ? 16'h8000 : 16'h7FFF)
                             : product[`ARDG_GAIN_FRAC +: 16];

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      valid_q  <= 1'b0;
      result_q <= 16'h0000;
      sat_q    <= 1'b0;
    end else begin
      valid_q <= valid_i;
      sat_q   <= valid_i & (sum_ovf | prod_ovf);
      if (valid_i) begin
        result_q <= prod_sat;
      end
    end
  end

  assign valid_o  = valid_q;
  assign result_o = result_q;
  assign sat_o    = sat_q;

endmodule

// >>> ardg_top.sv
// The Avalon-MM slave port was left to the implementer.
`include "ardg_defs.svh"

module ardg_top (
  input  wire logic        CORE_CLK_I,
  input  wire logic        RST_B_I,
  input  wire logic [31:0] AVS_ADDRESS_I,
  input  wire logic        AVS_READ_I,
  input  wire logic        AVS_WRITE_I,
  input  wire logic [31:0] AVS_WRITEDATA_I,
  input  wire logic [3:0]  AVS_BYTEENABLE_I,
  output logic      [31:0] AVS_READDATA_O,
  output logic             AVS_WAITREQUEST_O,
  input  wire logic [15:0] RESULT_I,
  input  wire logic        RESULT_VALID_I,
  output logic      [31:0] RAM_ADDRESS_O,
  output logic      [15:0] RAM_WRITEDATA_O,
  output logic             RAM_WRITE_O,
  input  wire logic        RAM_WAITREQUEST_I
);

  // Bus handshake state.
  logic        ack_q;
  logic [31:0] rdata_q;

  // Software-visible state.
  logic [15:0]                  gain_q;
  logic [15:0]                  offset_q;
  logic                         wrap_q;
  logic                         load_q;
  logic [`ARDG_PTR_W-1:1]       beg_q;
  logic [`ARDG_SIZE_W-1:0]      size_q;
  logic                         ovf_q;
  logic [4:1]                   evt_q;

  // DMA engine state.
  ardg_pkg::ardg_state_type     state_q;
  logic [`ARDG_PTR_W-1:1]       cur_q;
  logic [`ARDG_SIZE_W-1:0]      cnt_q;
  logic [15:0]                  wdata_q;

  // Gain stage outputs.
  logic                         corr_valid;
  ardg_pkg::ardg_sample_type    corr_data;
  logic                         corr_sat;

  // Decode.
  wire bus_req   = AVS_READ_I | AVS_WRITE_I;
  wire wr_take   = AVS_WRITE_I & ack_q;
  wire rd_first  = AVS_READ_I & ~ack_q;
  wire sel_off   = (AVS_ADDRESS_I == `ARDG_OFFSET_ADR);
  wire sel_gain  = (AVS_ADDRESS_I == `ARDG_GAIN_ADR);
  wire sel_cfg   = (AVS_ADDRESS_I == `ARDG_CFG_ADR);
  wire sel_stat  = (AVS_ADDRESS_I == `ARDG_STAT_ADR);
  wire sel_beg   = (AVS_ADDRESS_I == `ARDG_BEG_ADR);
  wire sel_size  = (AVS_ADDRESS_I == `ARDG_SIZE_ADR);
  wire sel_cur   = (AVS_ADDRESS_I == `ARDG_CUR_ADR);
  wire sel_evt   = (AVS_ADDRESS_I == `ARDG_EVT_ADR);

  wire active    = (state_q != ardg_pkg::ARDG_IDLE);

  wire [31:0] cfg_word  = {27'h0, 1'b0, 2'h0, wrap_q, load_q};
  wire [31:0] stat_word = {30'h0, ovf_q, active};
  wire [31:0] beg_word  = `ARDG_RAM_BASE | {18'h0, beg_q, 1'b0};
  wire [31:0] cur_word  = `ARDG_RAM_BASE | {18'h0, cur_q, 1'b0};
  wire [31:0] size_word = {19'h0, size_q};
  wire [31:0] evt_word  = {27'h0, evt_q, 1'b0};

  // Unmapped addresses read as zero and ignore writes.
  wire [31:0] rd_word =
    sel_off  ? {16'h0, offset_q} :
    sel_gain ? {16'h0, gain_q}   :
    sel_cfg  ? cfg_word          :
    sel_stat ? stat_word         :
    sel_beg  ? beg_word          :
    sel_size ? size_word         :
    sel_cur  ? cur_word          :
    sel_evt  ? evt_word          :
    32'h0000_0000;

  wire [31:0] be_mask = {{8{AVS_BYTEENABLE_I[3]}}, {8{AVS_BYTEENABLE_I[2]}},
                         {8{AVS_BYTEENABLE_I[1]}}, {8{AVS_BYTEENABLE_I[0]}}};
  wire [31:0] wr_merged = (rd_word & ~be_mask) | (AVS_WRITEDATA_I & be_mask);
  wire [31:0] wr_ones   = AVS_WRITEDATA_I & be_mask;

  // Control strobes from software writes.
  wire dma_rst   = wr_take & sel_cfg & wr_merged[`ARDG_CFG_RST];
  wire load_wr   = wr_take & sel_cfg & wr_merged[`ARDG_CFG_LOAD];
  wire [4:1] evt_clr = (wr_take & sel_evt) ? wr_ones[4:1] : 4'h0;

  // A start waits for any pending RAM write to finish so no write is torn.
  wire start     = load_q & (state_q != ardg_pkg::ARDG_WRITE) & ~dma_rst;

  // Buffer arithmetic in units of results.
  wire [`ARDG_SIZE_W-1:0] cnt_next  = cnt_q + 13'h0001;
  wire [`ARDG_SIZE_W-1:0] half_mark = {1'b0, size_q[`ARDG_SIZE_W-1:1]};
  wire                    wr_done   = (state_q == ardg_pkg::ARDG_WRITE) & ~RAM_WAITREQUEST_I;
  wire                    buf_full  = (cnt_next == size_q);
  wire                    buf_half  = (cnt_next == half_mark) & (half_mark != 13'h0000);
  wire                    size_zero = (size_q == 13'h0000);

  // Event sources.
  wire overrun   = corr_valid & ~active;
  wire [4:1] evt_set = {overrun, corr_sat, wr_done & buf_full, wr_done & buf_half};

  ardg_gain u_gain (
    .clk_i    (CORE_CLK_I),
    .rst_b_i  (RST_B_I),
    .valid_i  (RESULT_VALID_I),
    .data_i   (RESULT_I),
    .offset_i (offset_q),
    .gain_i   (gain_q),
    .valid_o  (corr_valid),
    .result_o (corr_data),
    .sat_o    (corr_sat)
  );

  // Every access holds waitrequest for exactly one cycle; read data is captured
  // during that cycle so it stands while waitrequest is low.
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q <= bus_req & ~ack_q;
      if (rd_first) begin
        rdata_q <= rd_word;
      end
    end
  end

  assign AVS_WAITREQUEST_O = bus_req & ~ack_q;
  assign AVS_READDATA_O    = rdata_q;

  // Plain read-write configuration registers.
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      gain_q   <= `ARDG_GAIN_RST;
      offset_q <= `ARDG_OFFSET_RST;
      wrap_q   <= 1'b0;
      beg_q    <= 13'h0000;
      size_q   <= `ARDG_SIZE_RST;
    end else if (wr_take) begin
      if (sel_gain) begin
        gain_q <= wr_merged[15:0];
      end
      if (sel_off) begin
        offset_q <= wr_merged[15:0];
      end
      if (sel_cfg) begin
        wrap_q <= wr_merged[`ARDG_CFG_WRAP];
      end
      if (sel_beg) begin
        beg_q <= wr_merged[`ARDG_PTR_W-1:1];
      end
      if (sel_size) begin
        size_q <= wr_merged[`ARDG_SIZE_W-1:0];
      end
    end
  end

  // The load bit is a request: it stays set until the engine takes it or a DMA reset clears it.
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      load_q <= 1'b0;
    end else if (dma_rst || start) begin
      load_q <= 1'b0;
    end else if (load_wr) begin
      load_q <= 1'b1;
    end
  end

  // Overrun is sticky and only the DMA reset clears it, never a status read.
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      ovf_q <= 1'b0;
    end else if (dma_rst) begin
      ovf_q <= 1'b0;
    end else if (overrun) begin
      ovf_q <= 1'b1;
    end
  end

  // Pending events are write-one-to-clear; a new event beats a clear.
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      evt_q <= 4'h0;
    end else begin
      evt_q <= (evt_q & ~evt_clr) | evt_set;
    end
  end

  // DMA engine. A result that arrives while a RAM write is still pending is
  // dropped; the converter is far slower than the RAM, so this only happens
  // when the RAM stalls for a whole conversion period.
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      state_q <= ardg_pkg::ARDG_IDLE;
      cur_q   <= 13'h0000;
      cnt_q   <= 13'h0000;
      wdata_q <= 16'h0000;
    end else if (dma_rst) begin
      state_q <= ardg_pkg::ARDG_IDLE;
      cur_q   <= beg_q;
      cnt_q   <= 13'h0000;
    end else begin
      case (state_q)
        ardg_pkg::ARDG_IDLE: begin
          if (start) begin
            cur_q   <= beg_q;
            cnt_q   <= 13'h0000;
            state_q <= size_zero ? ardg_pkg::ARDG_IDLE : ardg_pkg::ARDG_RUN;
          end
        end
        ardg_pkg::ARDG_RUN: begin
          if (start) begin
            cur_q   <= beg_q;
            cnt_q   <= 13'h0000;
            state_q <= size_zero ? ardg_pkg::ARDG_IDLE : ardg_pkg::ARDG_RUN;
          end else if (corr_valid) begin
            wdata_q <= corr_data;
            state_q <= ardg_pkg::ARDG_WRITE;
          end
        end
        ardg_pkg::ARDG_WRITE: begin
          if (wr_done) begin
            if (!buf_full) begin
              cur_q   <= cur_q + 13'h0001;
              cnt_q   <= cnt_next;
              state_q <= ardg_pkg::ARDG_RUN;
            end else if (wrap_q) begin
              cur_q   <= beg_q;
              cnt_q   <= 13'h0000;
              state_q <= ardg_pkg::ARDG_RUN;
            end else begin
              // The pointer still steps so it shows the end of the buffer.
              cur_q   <= cur_q + 13'h0001;
              cnt_q   <= cnt_next;
              state_q <= ardg_pkg::ARDG_IDLE;
            end
          end
        end
        default: begin
          state_q <= ardg_pkg::ARDG_IDLE;
        end
      endcase
    end
  end

  // RAM write port, Avalon-MM master style: the write holds until accepted, unless a DMA reset drops it first.
  assign RAM_WRITE_O     = (state_q == ardg_pkg::ARDG_WRITE);
  assign RAM_ADDRESS_O   = cur_word;
  assign RAM_WRITEDATA_O = wdata_q;

endmodule

// >>> ardg_ram_model.sv
module ardg_ram_model (
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  input  wire logic [31:0] addr_i,
  input  wire logic [15:0] data_i,
  input  wire logic        write_i,
  output logic             wait_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] addr_q[$];
  logic [15:0] data_q[$];
  int          seed = 32'h349CEBF1;
  // Stalls are redrawn at random every cycle, so writes meet both prompt and slow acceptance.
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wait_o <= 1'b1;
    end else begin
      if (write_i && !wait_o) begin
        addr_q.push_back(addr_i);
        data_q.push_back(data_i);
      end
      wait_o <= ($random(seed) % 3) != 0;
    end
  end
endmodule

// >>> ardg_properties.sv
`include "ardg_defs.svh"

module ardg_properties (
  input  wire logic        CORE_CLK_I,
  input  wire logic        RST_B_I,
  input  wire logic [31:0] AVS_ADDRESS_I,
  input  wire logic        AVS_READ_I,
  input  wire logic        AVS_WRITE_I,
  input  wire logic [31:0] AVS_WRITEDATA_I,
  input  wire logic [3:0]  AVS_BYTEENABLE_I,
  input  wire logic [31:0] AVS_READDATA_O,
  input  wire logic        AVS_WAITREQUEST_O,
  input  wire logic [15:0] RESULT_I,
  input  wire logic        RESULT_VALID_I,
  input  wire logic [31:0] RAM_ADDRESS_O,
  input  wire logic [15:0] RAM_WRITEDATA_O,
  input  wire logic        RAM_WRITE_O,
  input  wire logic        RAM_WAITREQUEST_I
);
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_B_I);
  wire rq = AVS_READ_I | AVS_WRITE_I;
  wire rd_ack = AVS_READ_I && !AVS_WAITREQUEST_O;
  chk_bus_one_wait: assert property (rq && !$past(rq) |-> AVS_WAITREQUEST_O ##1 !AVS_WAITREQUEST_O)
    else $error("bus answer not after one wait cycle");
  chk_bus_idle: assert property (!rq |-> !AVS_WAITREQUEST_O)
    else $error("waitrequest high without request");
  chk_ram_base: assert property (RAM_ADDRESS_O[31:14] == 18'h08000 && !RAM_ADDRESS_O[0])
    else $error("ram address outside buffer window or odd");
  chk_ram_hold: assert property (RAM_WRITE_O && RAM_WAITREQUEST_I |=>
    RAM_WRITE_O && $stable(RAM_ADDRESS_O) && $stable(RAM_WRITEDATA_O)) else $error("ram write not held");
  chk_ram_single: assert property (RAM_WRITE_O && !RAM_WAITREQUEST_I |=> !RAM_WRITE_O)
    else $error("ram write repeated");
  chk_result_lat: assert property ($rose(RAM_WRITE_O) |-> $past(RESULT_VALID_I, 2))
    else $error("ram write without result two cycles before");
  chk_stat_bits: assert property (rd_ack && AVS_ADDRESS_I == `ARDG_STAT_ADR |-> AVS_READDATA_O[31:2] == 30'h0)
    else $error("status upper bits set");
  chk_gain_width: assert property (rd_ack && AVS_ADDRESS_I == `ARDG_GAIN_ADR |-> AVS_READDATA_O[31:16] == 16'h0)
    else $error("gain upper bits set");
  chk_cfg_rst_zero: assert property (rd_ack && AVS_ADDRESS_I == `ARDG_CFG_ADR |-> AVS_READDATA_O[31:2] == 30'h0)
    else $error("config reset bit reads back");
  chk_cur_match: assert property (rd_ack && AVS_ADDRESS_I == `ARDG_CUR_ADR |-> AVS_READDATA_O == $past(RAM_ADDRESS_O))
    else $error("current address differs from ram address");
  cover property (RAM_WRITE_O && RAM_WAITREQUEST_I);
  cover property (RAM_WRITE_O && !RAM_WAITREQUEST_I);
  cover property (rd_ack && AVS_ADDRESS_I == `ARDG_STAT_ADR && AVS_READDATA_O[1]);
endmodule

bind ardg_top ardg_properties ardg_properties_i (.CORE_CLK_I(CORE_CLK_I), .RST_B_I(RST_B_I),
  .AVS_ADDRESS_I(AVS_ADDRESS_I), .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I),
  .AVS_WRITEDATA_I(AVS_WRITEDATA_I), .AVS_BYTEENABLE_I(AVS_BYTEENABLE_I), .AVS_READDATA_O(AVS_READDATA_O),
  .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .RESULT_I(RESULT_I), .RESULT_VALID_I(RESULT_VALID_I),
  .RAM_ADDRESS_O(RAM_ADDRESS_O), .RAM_WRITEDATA_O(RAM_WRITEDATA_O), .RAM_WRITE_O(RAM_WRITE_O),
  .RAM_WAITREQUEST_I(RAM_WAITREQUEST_I));

// >>> ardg_top_tb.sv
`include "ardg_defs.svh"

module ardg_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk, rst_b, rd, wr, wreq, res_v, ram_wr, ram_wait;
  logic [31:0] adr, wdat, rdat, ram_adr;
  logic [15:0] res, ram_dat;
  int          err_count, comparisons, seed, beg, size, wrap, cur, cnt, act, ovf, gain, off;
  logic [31:0] ra [9] = '{`ARDG_GAIN_ADR, `ARDG_CFG_ADR, `ARDG_STAT_ADR, `ARDG_BEG_ADR, `ARDG_SIZE_ADR,
                          `ARDG_CUR_ADR, `ARDG_OFFSET_ADR, `ARDG_EVT_ADR, 32'h4000_D030};
  logic [31:0] rv [9] = '{32'h8000, 32'h0, 32'h0, 32'h2000_0000, 32'h0, 32'h2000_0000, 32'h0, 32'h0, 32'h0};

  ardg_top ardg_top_i (.CORE_CLK_I(clk), .RST_B_I(rst_b), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd), .AVS_WRITE_I(wr),
    .AVS_WRITEDATA_I(wdat), .AVS_BYTEENABLE_I(4'hF), .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wreq),
    .RESULT_I(res), .RESULT_VALID_I(res_v), .RAM_ADDRESS_O(ram_adr), .RAM_WRITEDATA_O(ram_dat),
    .RAM_WRITE_O(ram_wr), .RAM_WAITREQUEST_I(ram_wait));
  ardg_ram_model ardg_ram_model_i (.clk_i(clk), .rst_b_i(rst_b), .addr_i(ram_adr), .data_i(ram_dat),
    .write_i(ram_wr), .wait_o(ram_wait));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Waitrequest is judged at the rising edge, where the slave takes the request.
  // Read data are taken at that same edge, and only then is the request dropped.
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    rd <= !w;
    wr <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    if (n >= 50) err_count++;
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic wreg(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rchk(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask

  function automatic longint sat(input longint v);
    return v > 32767 ? 32767 : (v < -32768 ? -32768 : v);
  endfunction

  function automatic logic [15:0] corr(input logic [15:0] x);
    longint s;
    s = sat(longint'($signed(x)) + off);
    return 16'(sat((s * gain) >>> 15));
  endfunction

  task automatic dma_reset();
    wreg(`ARDG_CFG_ADR, 32'h10);
    act = 0;
    ovf = 0;
    cur = beg;
    cnt = 0;
  endtask

  task automatic run(input int w, input int b, input int s, input int g, input int o);
    wrap = w;
    size = s;
    gain = g;
    off = o;
    beg = b & 32'h3FFE;
    cur = beg;
    cnt = 0;
    act = (s != 0);
    wreg(`ARDG_BEG_ADR, b);
    wreg(`ARDG_SIZE_ADR, s);
    wreg(`ARDG_GAIN_ADR, g);
    wreg(`ARDG_OFFSET_ADR, o & 32'hFFFF);
    wreg(`ARDG_CFG_ADR, w * 2 + 1);
    rchk(`ARDG_CFG_ADR, w * 2);
    rchk(`ARDG_BEG_ADR, 32'h2000_0000 | beg);
    rchk(`ARDG_SIZE_ADR, s);
  endtask

  task automatic smp(input logic [15:0] x);
    int n0;
    int t;
    n0 = ardg_ram_model_i.addr_q.size();
    t = 0;
    @(posedge clk);
    res <= x;
    res_v <= 1'b1;
    @(posedge clk);
    res_v <= 1'b0;
    while (act != 0 && ardg_ram_model_i.addr_q.size() == n0 && t < 100) begin
      @(posedge clk);
      t++;
    end
    repeat (3) @(posedge clk);
    chk(ardg_ram_model_i.addr_q.size(), n0 + act);
    if (act != 0) begin
      chk(ardg_ram_model_i.addr_q[n0], 32'h2000_0000 | cur);
      chk(ardg_ram_model_i.data_q[n0], corr(x));
      cur = (cur + 2) & 32'h3FFF;
      cnt++;
      if (cnt == size) begin
        cur = wrap ? beg : cur;
        cnt = 0;
        act = wrap;
      end
    end else begin
      ovf = 1;
    end
    rchk(`ARDG_STAT_ADR, ovf * 2 + act);
    rchk(`ARDG_CUR_ADR, 32'h2000_0000 | cur);
  endtask

  initial begin
    {rst_b, rd, wr, res_v, adr, wdat, res} = '0;
    {err_count, comparisons, act, ovf, off, beg, cur, cnt} = '0;
    gain = 32'h8000;
    seed = 32'h349CEBF1;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 9; i++) rchk(ra[i], rv[i]);
    $display("test reset values done");
    smp(16'h1234);
    wreg(`ARDG_CFG_ADR, 32'h0);
    rchk(`ARDG_STAT_ADR, 32'h2);
    dma_reset();
    rchk(`ARDG_STAT_ADR, 32'h0);
    $display("test overrun done");
    run(0, 32'h105, 3, $random(seed) & 32'hFFFF, $signed(16'($random(seed))));
    repeat (4) smp(16'($random(seed)));
    $display("test linear done");
    dma_reset();
    run(1, 32'h200, 2, $random(seed) & 32'hFFFF, $signed(16'($random(seed))));
    repeat (5) smp(16'($random(seed)));
    $display("test wrap done");
    dma_reset();
    wreg(`ARDG_EVT_ADR, 32'h1E);
    rchk(`ARDG_EVT_ADR, 32'h0);
    run(1, 32'h3FFC, 4, 32'hFFFF, 32'h7FFF);
    smp(16'h7FFF);
    smp(16'h8000);
    smp(16'h0001);
    smp(16'($random(seed)));
    rchk(`ARDG_EVT_ADR, 32'h0E);
    $display("test saturation done");
    end_of_test();
  end

  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    end_of_test();
  end
endmodule
